// ---- pcg_pkg.sv ----
// package for the link clock generator: register map, field positions, divider ratios
// assumes a 32-bit AHB-Lite register bus clocked by hclk
//
// ----------------------------------------------------------------
// Overview of operation
// ----------------------------------------------------------------
// Overview of operation
// - enable bit activates block and makes the clock pin open-drain; clearing disables it
// - prescaler makes two phases: one feeds pin generator, other feeds interrupt generator
// - pin carries generated clock only while clock output enable is set
// - interrupt trigger falls on the phase opposite the pin toggles
// - while enabled, pin level sampled into read-only status flag; reset clears it
// - pending flag set on each trigger, cleared by writing one or by reset
// - prescaler select: 1 divides by 480, 0 by 160; reset clears
// - frequency select: 00 by 1, 01 by 2, 10 by 4, 11 unused; reset clears
// - output frequency is bus frequency over prescaler ratio times select ratio
// - interrupt mask bit gates periodic interrupt; reset clears it
// - clock output enable turns open-drain output on or off; reset clears it
// - module enable gates the block's clock source; reset leaves it disabled
package pcg_pkg;
	// ----------------------------------------------------------------
	// register map
	// ----------------------------------------------------------------
	localparam logic [11:0] CTRL_STATUS_OFFSET = 12'h000;
	localparam logic [11:0] IRQ_MASK_OFFSET    = 12'h004;
	localparam logic [7:0]  CTRL_RESET         = 8'h00;

	// control/status field positions
	localparam int BIT_MODULE_ENABLE = 0;
	localparam int BIT_CLOCK_OUT_EN  = 1;
	localparam int BIT_IRQ_MASK      = 2;
	localparam int BIT_FSEL_LO       = 3;
	localparam int BIT_FSEL_HI       = 4;
	localparam int BIT_PRESCALE_SEL  = 5;
	localparam int BIT_IRQ_PENDING   = 6;
	localparam int BIT_PIN_LEVEL     = 7;

	// ----------------------------------------------------------------
	// divider ratios
	// ----------------------------------------------------------------
	localparam logic [8:0] PRESCALE_LOW   = 9'h0A0; // 160
	localparam logic [8:0] PRESCALE_HIGH  = 9'h1E0; // 480
	localparam logic [1:0] FSEL_DIV1      = 2'h0;
	localparam logic [1:0] FSEL_DIV2      = 2'h1;
	localparam logic [1:0] FSEL_DIV4      = 2'h2;
	localparam int         SYNC_STAGES    = 3;
endpackage

// ---- pcg_prescaler.sv ----
// prescaler: two-phase clock enables from the bus clock
// assumes divide ratio is held steady while running
`timescale 1ns/1ps
module pcg_prescaler (
	// clock and reset
	input  wire logic       hclk,
	input  wire logic       hresetn,
	// control
	input  wire logic       run,
	input  wire logic       sel_high,
	// phase pulses, a quarter prescale period apart
	output logic            phase_a,
	output logic            phase_b
);
	typedef struct packed {
		logic [8:0] count;
		logic       phase_a;
		logic       phase_b;
	} pcg_pre_s;

	pcg_pre_s state;
	pcg_pre_s next_state;
	logic [8:0] ratio;

	// count wraps at half the ratio: the pin toggles on phase a, so at frequency select by one a full pin cycle spans the ratio
	// phase b sits at mid-count, between two phase a pulses
	always_comb begin
		ratio = sel_high ? pcg_pkg::PRESCALE_HIGH : pcg_pkg::PRESCALE_LOW;
		next_state = state;
		next_state.phase_a = 1'b0;
		next_state.phase_b = 1'b0;
		if (!run) begin
			next_state.count = 9'h000;
		end else if (state.count == (ratio >> 1) - 9'h001) begin
			next_state.count   = 9'h000;
			next_state.phase_a = 1'b1;
		end else begin
			next_state.count = state.count + 9'h001;
			if (state.count == (ratio >> 2) - 9'h001) begin
				next_state.phase_b = 1'b1;
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

	assign phase_a = state.phase_a;
	assign phase_b = state.phase_b;
endmodule

// ---- pcg_pin_sync.sv ----
// three-flop synchroniser for the clock pin level
// assumes pin is asynchronous to hclk
`timescale 1ns/1ps
module pcg_pin_sync (
	// clock and reset
	input  wire logic hclk,
	input  wire logic hresetn,
	// pin in, stable level out
	input  wire logic pin_in,
	output logic      level
);
	typedef struct packed {
		logic [2:0] stages;
		logic       level;
	} pcg_sync_s;

	pcg_sync_s state;
	pcg_sync_s next_state;

	// level only changes once stages two and three agree
	always_comb begin
		next_state = state;
		next_state.stages = {state.stages[1:0], pin_in};
		if (state.stages[1] == state.stages[2]) begin
			next_state.level = state.stages[2];
		end
	end

	// idle line is pulled high, so reset to one
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state <= {3'h7, 1'b1};
		end else begin
			state <= next_state;
		end
	end

	assign level = state.level;
endmodule

// ---- pcg_clock_gen.sv ----
// link clock generator top: ahb-lite registers, divider chain, open-drain pin, interrupt
// assumes one ahb-lite master, an external pullup on the clock line
//
// The placing of the registers and the AHB-Lite register port were decided locally.
`timescale 1ns/1ps
module pcg_clock_gen (
	// clock and reset
	input  wire logic        hclk,
	input  wire logic        hresetn,
	// ahb-lite slave
	input  wire logic        hsel,
	input  wire logic [11:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	// open-drain clock pin
	input  wire logic        link_clk_in,
	output logic             link_clk_out,
	output logic             link_clk_oe,
	// interrupt
	output logic             irq
);
	typedef struct packed {
		logic        wr_pend;
		logic [11:0] wr_addr;
		logic [31:0] rdata;
		logic        module_enable;
		logic        clock_output_enable;
		logic        periodic_irq_mask;
		logic [1:0]  frequency_select;
		logic        prescale_sel;
		logic        periodic_irq_pending;
		logic        pin_level_status;
		logic [1:0]  fdiv;
		logic        clk_level;
		logic        oe;
		logic        irq;
		logic [7:0]  status_mask;
	} pcg_top_s;

	pcg_top_s state;
	pcg_top_s next_state;

	logic       phase_a;
	logic       phase_b;
	logic       pin_level;
	logic       fsel_tick;
	logic       irq_tick;
	logic       w1c_pending;

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	// frequency select code to fdiv wrap value (half periods per toggle minus one)
	function automatic logic [1:0] fsel_limit(input logic [1:0] code);
		case (code)
			pcg_pkg::FSEL_DIV1: fsel_limit = 2'h0;
			pcg_pkg::FSEL_DIV2: fsel_limit = 2'h1;
			pcg_pkg::FSEL_DIV4: fsel_limit = 2'h3;
			default:            fsel_limit = 2'h0; // unused code treated as by one
		endcase
	endfunction

	function automatic logic [7:0] ctrl_word(input pcg_top_s s);
		ctrl_word = '0;
		ctrl_word[pcg_pkg::BIT_MODULE_ENABLE] = s.module_enable;
		ctrl_word[pcg_pkg::BIT_CLOCK_OUT_EN]  = s.clock_output_enable;
		ctrl_word[pcg_pkg::BIT_IRQ_MASK]      = s.periodic_irq_mask;
		ctrl_word[pcg_pkg::BIT_FSEL_HI:pcg_pkg::BIT_FSEL_LO] = s.frequency_select;
		ctrl_word[pcg_pkg::BIT_PRESCALE_SEL]  = s.prescale_sel;
		ctrl_word[pcg_pkg::BIT_IRQ_PENDING]   = s.periodic_irq_pending;
		ctrl_word[pcg_pkg::BIT_PIN_LEVEL]     = s.pin_level_status;
	endfunction

	// ----------------------------------------------------------------
	// sub-blocks
	// ----------------------------------------------------------------
	// prescaler only runs while enabled, so the clock source is gated
	pcg_prescaler u_pre (
		.hclk     (hclk),
		.hresetn  (hresetn),
		.run      (state.module_enable),
		.sel_high (state.prescale_sel),
		.phase_a  (phase_a),
		.phase_b  (phase_b)
	);

	pcg_pin_sync u_sync (
		.hclk    (hclk),
		.hresetn (hresetn),
		.pin_in  (link_clk_in),
		.level   (pin_level)
	);

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		next_state = state;
		// phase a comes every half prescale; the pin toggles after the further divider
		// so one pin period is prescale x fsel bus cycles
		fsel_tick   = phase_a && (state.fdiv == fsel_limit(state.frequency_select));
		// interrupt on phase b of the last divided step, between two pin edges
		irq_tick    = phase_b && (state.fdiv == fsel_limit(state.frequency_select));
		w1c_pending = 1'b0;

		// data phase write; divider settings should only change while disabled
		if (state.wr_pend) begin
			case (state.wr_addr)
				pcg_pkg::CTRL_STATUS_OFFSET: begin
					next_state.module_enable       = hwdata[pcg_pkg::BIT_MODULE_ENABLE];
					next_state.clock_output_enable = hwdata[pcg_pkg::BIT_CLOCK_OUT_EN];
					next_state.periodic_irq_mask   = hwdata[pcg_pkg::BIT_IRQ_MASK];
					next_state.frequency_select    = hwdata[pcg_pkg::BIT_FSEL_HI:pcg_pkg::BIT_FSEL_LO];
					next_state.prescale_sel        = hwdata[pcg_pkg::BIT_PRESCALE_SEL];
					w1c_pending                    = hwdata[pcg_pkg::BIT_IRQ_PENDING];
				end
				pcg_pkg::IRQ_MASK_OFFSET: begin
					next_state.status_mask = hwdata[7:0];
				end
				default: begin
					// unmapped writes are dropped
				end
			endcase
		end

		// divider chain, restarted while disabled to avoid a stale phase
		if (!state.module_enable) begin
			next_state.fdiv      = 2'h0;
			next_state.clk_level = 1'b1;
		end else if (phase_a) begin
			if (fsel_tick) begin
				next_state.fdiv      = 2'h0;
				next_state.clk_level = !state.clk_level;
			end else begin
				next_state.fdiv = state.fdiv + 2'h1;
			end
		end

		// open drain: only ever pull low, release when high or output off
		next_state.oe = state.module_enable && state.clock_output_enable && !next_state.clk_level;

		// pending: set wins over a clear in the same cycle
		if (w1c_pending) begin
			next_state.periodic_irq_pending = 1'b0;
		end
		if (irq_tick && state.module_enable) begin
			next_state.periodic_irq_pending = 1'b1;
		end

		// pin status tracked only while enabled; holds last value otherwise
		if (state.module_enable) begin
			next_state.pin_level_status = pin_level;
		end

		// address phase: read data from the updated image, so a read right after a write sees it
		next_state.wr_pend = 1'b0;
		if (hsel && hready && htrans[1]) begin
			next_state.wr_pend = hwrite;
			next_state.wr_addr = haddr;
			case (haddr)
				pcg_pkg::CTRL_STATUS_OFFSET: next_state.rdata = {24'h000000, ctrl_word(next_state)};
				pcg_pkg::IRQ_MASK_OFFSET:    next_state.rdata = {24'h000000, next_state.status_mask};
				default:                     next_state.rdata = 32'h00000000;
			endcase
		end

		// interrupt level; mask register gates the same status bit again
		next_state.irq = next_state.periodic_irq_pending && next_state.periodic_irq_mask
			&& next_state.status_mask[pcg_pkg::BIT_IRQ_PENDING];
	end

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state              <= '0;
			state.clk_level    <= 1'b1;
			state.status_mask  <= 8'hFF;
		end else begin
			state <= next_state;
		end
	end

	// zero wait states, always okay
	assign hrdata       = state.rdata;
	assign hreadyout    = 1'b1;
	assign hresp        = 1'b0;
	assign link_clk_out = 1'b0;
	assign link_clk_oe  = state.oe;
	assign irq          = state.irq;
endmodule

// ---- pcg_properties.sv ----
// checker for the link clock generator: bus answer, pin timing, interrupt gating
// assumes the top module's ports only; it shadows control writes itself
`timescale 1ns/1ps
module pcg_properties (
	// clock and reset
	input wire logic        hclk,
	input wire logic        hresetn,
	// bus
	input wire logic        hsel,
	input wire logic [11:0] haddr,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic        hready,
	input wire logic [31:0] hwdata,
	input wire logic        hreadyout,
	input wire logic        hresp,
	// pin and interrupt
	input wire logic        link_clk_out,
	input wire logic        link_clk_oe,
	input wire logic        irq
);
	logic        wr_ph, sh_m6, seen, oe_q, chg, run;
	logic [11:0] wa, half;
	logic [5:0]  sh;
	logic [15:0] cnt;

	// ----------------------------------------------------------------
	// helper logic
	// ----------------------------------------------------------------
	// expected half period; code 11 acts as divide by 1
	assign half = (sh[5] ? 12'h0F0 : 12'h050) << ((sh[4:3] == 2'h1) ? 1 : (sh[4:3] == 2'h2) ? 2 : 0);
	assign chg  = link_clk_oe != oe_q;
	assign run  = sh[0] && sh[1];

	// shadow of written bits; any write restarts the period check, since a new setting may glitch
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_ph <= 1'h0;
			wa    <= 12'h000;
			sh    <= 6'h00;
			sh_m6 <= 1'h1;
			oe_q  <= 1'h0;
			cnt   <= 16'hFFFF;
			seen  <= 1'h0;
		end else begin
			wr_ph <= hsel && hready && htrans[1] && hwrite;
			wa    <= haddr;
			oe_q  <= link_clk_oe;
			if (wr_ph && wa == 12'h000)
				sh <= hwdata[5:0];
			if (wr_ph && wa == 12'h004)
				sh_m6 <= hwdata[6];
			cnt <= chg ? 16'h0000 : cnt + {15'h0000, cnt != 16'hFFFF};
			seen <= wr_ph ? 1'h0 : (seen || chg);
		end
	end

	// ----------------------------------------------------------------
	// properties
	// ----------------------------------------------------------------
	property p_bus_okay;
		@(posedge hclk) disable iff (!hresetn) hreadyout && !hresp;
	endproperty
	a_bus_okay: assert property (p_bus_okay) else $error("bus answer not ready or not okay");
	property p_drain_low;
		@(posedge hclk) disable iff (!hresetn) !link_clk_out;
	endproperty
	a_drain_low: assert property (p_drain_low) else $error("pin driven high");
	property p_off_released;
		@(posedge hclk) disable iff (!hresetn) (!sh[0] || !sh[1]) [*2] |-> !link_clk_oe;
	endproperty
	a_off_released: assert property (p_off_released) else $error("pin pulled while off");
	property p_half_period;
		@(posedge hclk) disable iff (!hresetn) chg && seen && run |-> cnt == {4'h0, half} - 16'h0001;
	endproperty
	a_half_period: assert property (p_half_period) else $error("pin half period wrong");
	property p_toggle_due;
		@(posedge hclk) disable iff (!hresetn) seen && run |-> cnt < {4'h0, half};
	endproperty
	a_toggle_due: assert property (p_toggle_due) else $error("pin toggle overdue");
	property p_irq_gated;
		@(posedge hclk) disable iff (!hresetn) (!sh[2] || !sh_m6) [*2] |-> !irq;
	endproperty
	a_irq_gated: assert property (p_irq_gated) else $error("irq while masked");
	property p_irq_w1c;
		@(posedge hclk) disable iff (!hresetn) wr_ph && wa == 12'h000 && hwdata[6] |-> ##[1:2] !irq;
	endproperty
	a_irq_w1c: assert property (p_irq_w1c) else $error("pending not cleared");
	property p_irq_between;
		@(posedge hclk) disable iff (!hresetn) $rose(irq) && $past(sh[2]) && $past(sh_m6) |-> cnt > 16'h0010;
	endproperty
	a_irq_between: assert property (p_irq_between) else $error("irq near a pin edge");
endmodule

bind pcg_clock_gen pcg_properties u_props (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
	.htrans(htrans), .hwrite(hwrite), .hready(hready), .hwdata(hwdata), .hreadyout(hreadyout),
	.hresp(hresp), .link_clk_out(link_clk_out), .link_clk_oe(link_clk_oe), .irq(irq));

// ---- pcg_peer.sv ----
// peer on the open-drain clock line: pullup plus a hold-low from the bench
// assumes the device only ever pulls the line low
`timescale 1ns/1ps
module pcg_peer (
	// device side
	input  wire logic link_clk_oe,
	// peer control
	input  wire logic hold_low,
	// resolved line
	output logic      line
);
	// wired-and with pullup; a released line rests high, never at its last value
	assign line = !(link_clk_oe || hold_low);
endmodule

// ---- pcg_clock_gen_tb.sv ----
// testbench for the link clock generator: register access, pin timing, interrupt
// assumes zero-wait ahb-lite slave and the peer model on the clock line
`timescale 1ns/1ps
module pcg_clock_gen_tb;
	logic        hclk, hresetn, hsel, hwrite, hready, hold_low, link_in, p;
	logic        hreadyout, hresp, link_clk_out, link_clk_oe, irq;
	logic [1:0]  htrans, f;
	logic [2:0]  hsize;
	logic [11:0] haddr;
	logic [31:0] hwdata, hrdata, rd;
	int          error_cnt, comparisons, n;

	assign hready = hreadyout;
	pcg_clock_gen dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .link_clk_in(link_in), .link_clk_out(link_clk_out),
		.link_clk_oe(link_clk_oe), .irq(irq));
	pcg_peer u_peer (.link_clk_oe(link_clk_oe), .hold_low(hold_low), .line(link_in));

	// ----------------------------------------------------------------
	// tasks
	// ----------------------------------------------------------------
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			error_cnt++;
			$display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic tally_and_finish;
		if (error_cnt == 0 && comparisons > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// bounded wait for a level; a stuck signal ends the run
	task automatic wait_for(input logic v, input int lim, input int sel);
		int i;
		i = 0;
		do begin
			@(posedge hclk);
			i++;
		end while ((sel == 0 ? hready : irq) !== v && i < lim);
		if (i >= lim) begin
			error_cnt++;
			tally_and_finish;
		end
	endtask
	task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
		hsel   <= 1'h1;
		haddr  <= a;
		htrans <= 2'h2;
		hwrite <= w;
		wait_for(1'h1, 50, 0);
		hsel   <= 1'h0;
		htrans <= 2'h0;
		hwdata <= d;
		wait_for(1'h1, 50, 0);
		rd = hrdata;
	endtask
	// cycles until the pin enable next changes
	task automatic edge_wait(output int c);
		logic o;
		o = link_clk_oe;
		c = 0;
		do begin
			@(posedge hclk);
			c++;
		end while (link_clk_oe === o && c < 5000);
		if (c >= 5000) begin
			error_cnt++;
			tally_and_finish;
		end
	endtask

	initial begin
		hclk = 1'h0;
		forever #2 hclk = ~hclk;
	end

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		{hresetn, hsel, hwrite, hold_low, htrans, haddr, hwdata} = '0;
		hsize = 3'h2;
		error_cnt = 0;
		comparisons = 0;
		repeat (10) @(posedge hclk);
		hresetn <= 1'h1;
		@(posedge hclk);
		chk({irq, link_clk_oe}, 32'h0);
		bus(1'h0, 12'h000, 32'h0);
		chk(rd, {24'h0, pcg_pkg::CTRL_RESET});
		bus(1'h0, 12'h004, 32'h0);
		chk(rd, 32'h0000_00FF);
		bus(1'h1, 12'h004, 32'h0000_0040);
		bus(1'h0, 12'h004, 32'h0);
		chk(rd, 32'h0000_0040);
		bus(1'h1, 12'h008, 32'h0000_00FF);
		bus(1'h0, 12'h008, 32'h0);
		chk(rd, 32'h0);
		// pin level follows the line while enabled, output off
		bus(1'h1, 12'h000, 32'h0000_0001);
		repeat (8) @(posedge hclk);
		bus(1'h0, 12'h000, 32'h0);
		chk(rd, 32'h0000_0081);
		chk(link_clk_oe, 32'h0);
		hold_low <= 1'h1;
		repeat (8) @(posedge hclk);
		bus(1'h0, 12'h000, 32'h0);
		chk(rd, 32'h0000_0001);
		hold_low <= 1'h0;
		// each frequency select code at prescale 160, then prescale 480 at by one, changed only while disabled
		for (int k = 0; k < 5; k++) begin
			f = (k == 4) ? 2'h0 : k[1:0];
			p = (k == 4);
			bus(1'h1, 12'h000, 32'h0);
			bus(1'h1, 12'h000, {26'h0, p, f, 3'h0});
			bus(1'h1, 12'h000, {26'h0, p, f, 3'h3});
			edge_wait(n);
			edge_wait(n);
			chk(n, (p ? 480 : 160) * (f == 2'h1 ? 2 : f == 2'h2 ? 4 : 1) / 2);
			bus(1'h0, 12'h000, 32'h0);
			chk(rd[5:0], {p, f, 3'h3});
		end
		// interrupt raise, clear, mask
		bus(1'h1, 12'h000, 32'h0);
		bus(1'h1, 12'h000, 32'h0000_0007);
		wait_for(1'h1, 400, 1);
		bus(1'h0, 12'h000, 32'h0);
		chk(rd[6], 32'h1);
		bus(1'h1, 12'h000, 32'h0000_0047);
		repeat (2) @(posedge hclk);
		chk(irq, 32'h0);
		bus(1'h1, 12'h004, 32'h0);
		repeat (200) @(posedge hclk);
		chk(irq, 32'h0);
		bus(1'h0, 12'h000, 32'h0);
		chk(rd[6], 32'h1);
		bus(1'h1, 12'h004, 32'h0000_00FF);
		repeat (2) @(posedge hclk);
		chk(irq, 32'h1);
		bus(1'h1, 12'h000, 32'h0000_0003);
		repeat (2) @(posedge hclk);
		chk(irq, 32'h0);
		// disable releases the pin for good
		bus(1'h1, 12'h000, 32'h0);
		repeat (400) @(posedge hclk);
		chk(link_clk_oe, 32'h0);
		tally_and_finish;
	end
endmodule
